// ==== rtl/spac_core.sv ====
// Converter setup registers and measurement sequencer for proximity and ambient channels
`timescale 1ns/1ps
module spac_core #(
  parameter int INTEG_CLKS = 512
) (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic [7:0] i_addr,
  input wire logic [7:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [7:0] o_rdata,
  input wire logic i_meas_start,
  input wire spac_pkg::spac_kind_t i_meas_kind,
  output spac_pkg::spac_conv_t o_conv,
  output logic o_busy,
  output logic o_done
);

  // ---------------------------------------------------------------------------
  // Elaboration checks
  // ---------------------------------------------------------------------------
  if (INTEG_CLKS < 1 || INTEG_CLKS > 65535) begin : g_bad_integ
    $error("INTEG_CLKS must lie between 1 and 65535");
  end

  localparam logic [15:0] INTEG_LEN = 16'(INTEG_CLKS);
  localparam logic [15:0] BASE_DIV = 16'(spac_pkg::ADC_CLK_CYC);

  // ---------------------------------------------------------------------------
  // Register file
  // ---------------------------------------------------------------------------
  logic [7:0] prox_gain_q;
  logic [7:0] prox_misc_q;
  logic [7:0] ir_sel_q;
  logic [7:0] aux_sel_q;
  logic [7:0] vis_rec_q;
  logic [7:0] vis_gain_q;
  logic [7:0] rdata_d;

  // Writes keep only implemented bits so reserved bits never hold a one
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      prox_gain_q <= spac_pkg::RST_PROX_GAIN;
      prox_misc_q <= spac_pkg::RST_PROX_MISC;
      ir_sel_q <= spac_pkg::RST_IR_SEL;
      aux_sel_q <= spac_pkg::RST_AUX_SEL;
      vis_rec_q <= spac_pkg::RST_VIS_REC;
      vis_gain_q <= spac_pkg::RST_VIS_GAIN;
    end else if (i_wr) begin
      case (i_addr)
        spac_pkg::OFS_PROX_GAIN: prox_gain_q <= i_wdata & spac_pkg::MSK_GAIN;
        spac_pkg::OFS_PROX_MISC: prox_misc_q <= i_wdata & spac_pkg::MSK_PROX_MISC;
        spac_pkg::OFS_IR_SEL: ir_sel_q <= i_wdata;
        spac_pkg::OFS_AUX_SEL: aux_sel_q <= i_wdata;
        spac_pkg::OFS_VIS_REC: vis_rec_q <= i_wdata & spac_pkg::MSK_VIS_REC;
        spac_pkg::OFS_VIS_GAIN: vis_gain_q <= i_wdata & spac_pkg::MSK_GAIN;
        default: begin
        end
      endcase
    end
  end

  // Read decode; unmapped addresses answer zero
  always_comb begin
    case (i_addr)
      spac_pkg::OFS_PROX_GAIN: rdata_d = prox_gain_q;
      spac_pkg::OFS_PROX_MISC: rdata_d = prox_misc_q;
      spac_pkg::OFS_IR_SEL: rdata_d = ir_sel_q;
      spac_pkg::OFS_AUX_SEL: rdata_d = aux_sel_q;
      spac_pkg::OFS_VIS_REC: rdata_d = vis_rec_q;
      spac_pkg::OFS_VIS_GAIN: rdata_d = vis_gain_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // Read data stands only in the cycle after the strobe
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_rdata <= 8'h00;
    end else begin
      o_rdata <= i_rd ? rdata_d : 8'h00;
    end
  end

  // ---------------------------------------------------------------------------
  // Measurement setup captured at start
  // ---------------------------------------------------------------------------
  spac_pkg::spac_state_t state_q;
  spac_pkg::spac_state_t state_d;
  spac_pkg::spac_kind_t kind_q;
  logic [2:0] gain_q;
  logic [2:0] rec_q;
  logic range_q;
  logic normal_q;
  logic [7:0] sel_q;
  logic [7:0] sel_d;
  logic start_ok;

  assign start_ok = i_meas_start && (state_q == spac_pkg::ST_IDLE);

  // Input routing per measurement kind
  always_comb begin
    case (i_meas_kind)
      spac_pkg::KIND_IR: sel_d = ir_sel_q;
      spac_pkg::KIND_AUX: sel_d = aux_sel_q;
      spac_pkg::KIND_VIS: sel_d = spac_pkg::SEL_VIS_PD;
      default: sel_d = spac_pkg::SEL_NONE;
    endcase
  end

  // Settings are frozen for the whole measurement so a host write mid-run
  // cannot stretch or cut a phase already counting
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      kind_q <= spac_pkg::KIND_PROX;
      gain_q <= 3'h0;
      rec_q <= 3'h0;
      range_q <= 1'b0;
      normal_q <= 1'b1;
      sel_q <= 8'h00;
    end else if (start_ok) begin
      kind_q <= i_meas_kind;
      sel_q <= sel_d;
      rec_q <= vis_rec_q[spac_pkg::REC_LSB +: spac_pkg::REC_W];
      range_q <= prox_misc_q[spac_pkg::RANGE_BIT];
      normal_q <= prox_misc_q[spac_pkg::MODE_BIT];
      case (i_meas_kind)
        spac_pkg::KIND_PROX: gain_q <= prox_gain_q[spac_pkg::GAIN_LSB +: spac_pkg::GAIN_W];
        spac_pkg::KIND_VIS: gain_q <= vis_gain_q[spac_pkg::GAIN_LSB +: spac_pkg::GAIN_W];
        default: gain_q <= 3'h0;
      endcase
    end
  end

  // ---------------------------------------------------------------------------
  // Converter clock divider
  // ---------------------------------------------------------------------------
  logic [15:0] div_cnt_q;
  logic [15:0] div_lim;
  logic active;
  logic tick;

  assign active = (state_q == spac_pkg::ST_RECOVER) || (state_q == spac_pkg::ST_EMIT)
                  || (state_q == spac_pkg::ST_INTEG);
  assign div_lim = (BASE_DIV << gain_q) - 16'h0001;
  assign tick = active && (div_cnt_q == div_lim);

  // One converter clock lasts the base period times two to the gain
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      div_cnt_q <= 16'h0000;
    end else if (!active || tick) begin
      div_cnt_q <= 16'h0000;
    end else begin
      div_cnt_q <= div_cnt_q + 16'h0001;
    end
  end

  // ---------------------------------------------------------------------------
  // Phase length counter
  // ---------------------------------------------------------------------------
  function automatic logic [15:0] rec_len(input logic [2:0] code);
    logic [15:0] len;
    len = 16'h0001;
    if (code != 3'h0) begin
      // Widened shift amount: codes 6 and 7 would wrap in three bits
      len = (16'h0001 << ({1'b0, code} + 4'h2)) - 16'h0001;
    end
    return len;
  endfunction : rec_len

  logic [15:0] clk_cnt_q;
  logic [15:0] phase_len;
  logic phase_end;

  // Count stays fixed; the gain stretches each clock instead
  assign phase_len = (state_q == spac_pkg::ST_RECOVER) ? rec_len(rec_q) : INTEG_LEN;
  assign phase_end = tick && (clk_cnt_q == phase_len - 16'h0001);

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      clk_cnt_q <= 16'h0000;
    end else if (!active || phase_end) begin
      clk_cnt_q <= 16'h0000;
    end else if (tick) begin
      clk_cnt_q <= clk_cnt_q + 16'h0001;
    end
  end

  // ---------------------------------------------------------------------------
  // Sequencer
  // ---------------------------------------------------------------------------
  always_comb begin
    state_d = state_q;
    case (state_q)
      spac_pkg::ST_IDLE: begin
        if (start_ok) begin
          case (i_meas_kind)
            spac_pkg::KIND_PROX: state_d = spac_pkg::ST_EMIT;
            spac_pkg::KIND_VIS: state_d = spac_pkg::ST_RECOVER;
            default: state_d = spac_pkg::ST_INTEG;
          endcase
        end
      end
      spac_pkg::ST_RECOVER: begin
        if (phase_end) begin
          state_d = spac_pkg::ST_INTEG;
        end
      end
      spac_pkg::ST_EMIT: begin
        if (phase_end) begin
          state_d = spac_pkg::ST_DONE;
        end
      end
      spac_pkg::ST_INTEG: begin
        if (phase_end) begin
          state_d = spac_pkg::ST_DONE;
        end
      end
      spac_pkg::ST_DONE: state_d = spac_pkg::ST_IDLE;
      default: state_d = spac_pkg::ST_IDLE;
    endcase
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      state_q <= spac_pkg::ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // ---------------------------------------------------------------------------
  // Converter control outputs, registered one cycle behind the sequencer
  // ---------------------------------------------------------------------------
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_conv <= '0;
      o_done <= 1'b0;
    end else begin
      // Raw mode runs without a reference pulse, so the emitter stays dark
      o_conv.emitter_on <= (state_q == spac_pkg::ST_EMIT) && normal_q;
      o_conv.integrate <= (state_q == spac_pkg::ST_EMIT) || (state_q == spac_pkg::ST_INTEG);
      o_conv.high_range <= active && (kind_q == spac_pkg::KIND_PROX) && range_q;
      o_conv.conv_tick <= tick;
      o_conv.input_sel <= active ? sel_q : spac_pkg::SEL_NONE;
      o_done <= (state_q == spac_pkg::ST_DONE);
    end
  end

  // Busy covers the whole run so a start is never silently dropped unseen
  assign o_busy = (state_q != spac_pkg::ST_IDLE);

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  sequence s_prox_start;
    start_ok && (i_meas_kind == spac_pkg::KIND_PROX);
  endsequence

  sequence s_vis_start;
    start_ok && (i_meas_kind == spac_pkg::KIND_VIS);
  endsequence

  a_prox_emit_entry: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    s_prox_start |=> (state_q == spac_pkg::ST_EMIT) && (gain_q == $past(prox_gain_q[2:0])))
    else $error("Proximity start did not capture gain");

  a_unity_divide: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (active && gain_q == 3'h0 && BASE_DIV == 16'h0001) |-> tick)
    else $error("Gain zero must tick every converter clock");

  a_tick_spacing: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (tick && gain_q == 3'h1 && BASE_DIV == 16'h0001) |=> (!tick || !active) ##1 (tick || !active))
    else $error("Gain one tick spacing wrong");

  a_range_follow: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    s_prox_start ##1 active |=> (o_conv.high_range == range_q))
    else $error("High range output does not follow setting");

  a_misc_reset: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $past(i_rst) |-> (prox_misc_q == spac_pkg::RST_PROX_MISC))
    else $error("Misc register reset value wrong");

  a_raw_dark: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_conv.emitter_on |-> $past(normal_q) && $past(state_q == spac_pkg::ST_EMIT))
    else $error("Emitter on outside normal emit phase");

  a_ir_route: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (start_ok && i_meas_kind == spac_pkg::KIND_IR) |=> ##1 (o_conv.input_sel == $past(ir_sel_q, 2)))
    else $error("Ambient infrared input not routed");

  a_aux_route: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (start_ok && i_meas_kind == spac_pkg::KIND_AUX) |=> ##1 (o_conv.input_sel == $past(aux_sel_q, 2)))
    else $error("Auxiliary input not routed");

  a_rec_length: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (state_q == spac_pkg::ST_RECOVER && state_d == spac_pkg::ST_INTEG) |-> tick
      && (clk_cnt_q == rec_len(rec_q) - 16'h0001))
    else $error("Recovery length mismatch");

  a_vis_recover: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    s_vis_start |=> (state_q == spac_pkg::ST_RECOVER) && (gain_q == $past(vis_gain_q[2:0])))
    else $error("Visible start did not capture gain");

  a_gain_reserved: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_rd && (i_addr == spac_pkg::OFS_PROX_GAIN || i_addr == spac_pkg::OFS_VIS_GAIN))
      |=> (o_rdata[7:3] == 5'h00))
    else $error("Reserved gain bits read nonzero");

  a_done_pulse: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    o_done |=> !o_done)
    else $error("Done longer than one cycle");

  // Normal mode must light the emitter for the whole emit phase
  a_emit_normal: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (state_q == spac_pkg::ST_EMIT && normal_q) |=> o_conv.emitter_on)
    else $error("Emitter dark in normal emit phase");

  a_aux_reset: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    $past(i_rst) |-> (aux_sel_q == spac_pkg::RST_AUX_SEL))
    else $error("Auxiliary select reset value wrong");

  // A start while busy must leave the captured setup untouched
  a_start_ignored: assert property (@(posedge i_ref_clk) disable iff (i_rst)
    (i_meas_start && o_busy) |=> $stable(kind_q) && $stable(gain_q) && $stable(sel_q))
    else $error("Start taken while busy");

endmodule : spac_core

// ==== rtl/spac_pkg.sv ====
// Package with the register map, field layout and timing constants of the converter setup block
// ---------------------------------------------------------------------------
// ---------------------------------------------------------------------------
package spac_pkg;

  // ---------------------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------------------
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] OFS_PROX_GAIN = 8'h0B;
  localparam logic [7:0] OFS_PROX_MISC = 8'h0C;
  localparam logic [7:0] OFS_IR_SEL = 8'h0E;
  localparam logic [7:0] OFS_AUX_SEL = 8'h0F;
  localparam logic [7:0] OFS_VIS_REC = 8'h10;
  localparam logic [7:0] OFS_VIS_GAIN = 8'h11;

  // Reset values
  localparam logic [7:0] RST_PROX_GAIN = 8'h00;
  localparam logic [7:0] RST_PROX_MISC = 8'h04;
  localparam logic [7:0] RST_IR_SEL = 8'h00;
  localparam logic [7:0] RST_AUX_SEL = 8'h65;
  localparam logic [7:0] RST_VIS_REC = 8'h70;
  localparam logic [7:0] RST_VIS_GAIN = 8'h00;

  // Implemented bits; everything else is reserved and reads zero
  localparam logic [7:0] MSK_GAIN = 8'h07;
  localparam logic [7:0] MSK_PROX_MISC = 8'h24;
  localparam logic [7:0] MSK_FULL = 8'hFF;
  localparam logic [7:0] MSK_VIS_REC = 8'h70;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int GAIN_LSB = 0;
  localparam int GAIN_W = 3;
  localparam int RANGE_BIT = 5;
  localparam int MODE_BIT = 2;
  localparam int REC_LSB = 4;
  localparam int REC_W = 3;

  // Input selection codes
  localparam logic [7:0] SEL_IR_SMALL = 8'h00;
  localparam logic [7:0] SEL_IR_LARGE = 8'h03;
  localparam logic [7:0] SEL_AUX_TEMP = 8'h65;
  localparam logic [7:0] SEL_AUX_VDD = 8'h75;
  localparam logic [7:0] SEL_VIS_PD = 8'h02;
  localparam logic [7:0] SEL_NONE = 8'h00;

  // ---------------------------------------------------------------------------
  // Timing
  // ---------------------------------------------------------------------------
  localparam int REF_CLK_KHZ = 10000;
  localparam int ADC_CLK_NS = 50;
  localparam int ADC_CLK_RAW = (ADC_CLK_NS * REF_CLK_KHZ + 999999) / 1000000;
  localparam int ADC_CLK_CYC = (ADC_CLK_RAW < 1) ? 1 : ADC_CLK_RAW;
  localparam int CNT_W = 16;

  typedef enum logic [1:0] {
    KIND_PROX = 2'h0,
    KIND_VIS = 2'h1,
    KIND_IR = 2'h2,
    KIND_AUX = 2'h3
  } spac_kind_t;

  // Gray codes along idle, recover, emit/integrate, done
  typedef enum logic [2:0] {
    ST_IDLE = 3'h0,
    ST_RECOVER = 3'h1,
    ST_EMIT = 3'h3,
    ST_INTEG = 3'h2,
    ST_DONE = 3'h6
  } spac_state_t;

  typedef struct packed {
    logic emitter_on;
    logic integrate;
    logic high_range;
    logic conv_tick;
    logic [7:0] input_sel;
  } spac_conv_t;

endpackage : spac_pkg

// ==== tb/sensor_adc_measurement_config_test.sv ====
// Self-checking bench for the converter setup registers and measurement sequencer
`timescale 1ns/1ps
module sensor_adc_measurement_config_test;
  // ---------------------------------------------------------------------------
  // Stimulus signals and bench state
  // ---------------------------------------------------------------------------
  localparam int N_CLK = 4; // Short integration keeps the run well under budget
  logic i_ref_clk = 1'b0;
  logic i_rst = 1'b1;
  logic [7:0] i_addr = 8'h00;
  logic [7:0] i_wdata = 8'h00;
  logic i_wr = 1'b0;
  logic i_rd = 1'b0;
  logic i_meas_start = 1'b0;
  spac_pkg::spac_kind_t i_meas_kind = spac_pkg::KIND_PROX;
  logic [7:0] o_rdata;
  spac_pkg::spac_conv_t o_conv;
  logic o_busy;
  logic o_done;
  int err_total = 0;
  int comparisons = 0;
  int seed = 80521;
  // Register table: offsets, reset values, implemented bits, bench copy
  logic [7:0] offs [6] = '{8'h0B, 8'h0C, 8'h0E, 8'h0F, 8'h10, 8'h11};
  logic [7:0] rsts [6] = '{8'h00, 8'h04, 8'h00, 8'h65, 8'h70, 8'h00};
  logic [7:0] msks [6] = '{8'h07, 8'h24, 8'hFF, 8'hFF, 8'h70, 8'h07};
  logic [7:0] regs [6];

  // 100 ns reference clock
  always #50 i_ref_clk = ~i_ref_clk;

  spac_core #(
    .INTEG_CLKS(N_CLK)
  ) dut (
    .i_ref_clk(i_ref_clk),
    .i_rst(i_rst),
    .i_addr(i_addr),
    .i_wdata(i_wdata),
    .i_wr(i_wr),
    .i_rd(i_rd),
    .o_rdata(o_rdata),
    .i_meas_start(i_meas_start),
    .i_meas_kind(i_meas_kind),
    .o_conv(o_conv),
    .o_busy(o_busy),
    .o_done(o_done)
  );

  // ---------------------------------------------------------------------------
  // Helpers
  // ---------------------------------------------------------------------------
  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic give_verdict();
    if (err_total == 0 && comparisons > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : give_verdict

  // Index into the register table, -1 for a hole in the map
  function automatic int idx(input logic [7:0] a);
    for (int i = 0; i < 6; i++) begin
      if (offs[i] == a) return i;
    end
    return -1;
  endfunction : idx

  // Recovery length in converter clocks for a 3-bit code
  function automatic int rec_len(input logic [2:0] c);
    return (c == 3'h0) ? 1 : (1 << (int'(c) + 2)) - 1;
  endfunction : rec_len

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_ref_clk);
    i_wr <= 1'b1;
    i_addr <= a;
    i_wdata <= d;
    @(posedge i_ref_clk);
    i_wr <= 1'b0;
  endtask : wr

  // Data stand one cycle after the strobe, then the port falls back to zero
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge i_ref_clk);
    i_rd <= 1'b1;
    i_addr <= a;
    @(posedge i_ref_clk);
    i_rd <= 1'b0;
    #1;
    d = o_rdata;
    @(posedge i_ref_clk);
    #1;
    check("rdata after read", o_rdata, 16'h0000);
  endtask : rd

  // Write and keep the bench copy, with reserved bits dropped
  task automatic set_reg(input int i, input logic [7:0] d);
    wr(offs[i], d);
    regs[i] = d & msks[i];
  endtask : set_reg

  // One measurement; a second start inside the busy window must be ignored
  task automatic meas(input spac_pkg::spac_kind_t kind, input bit dup);
    int dv, rc, n, rise_at, ticks, done_at;
    logic [7:0] sel;
    dv = 1;
    rc = 0;
    rise_at = 0;
    ticks = 0;
    done_at = 0;
    sel = 8'h00;
    case (kind)
      spac_pkg::KIND_PROX: dv = 1 << regs[0][2:0];
      spac_pkg::KIND_VIS: begin
        dv = 1 << regs[5][2:0];
        rc = rec_len(regs[4][6:4]);
        sel = 8'h02;
      end
      spac_pkg::KIND_IR: sel = regs[2];
      default: sel = regs[3];
    endcase
    @(posedge i_ref_clk);
    i_meas_start <= 1'b1;
    i_meas_kind <= kind;
    for (n = 1; n <= 6000 && done_at == 0; n++) begin
      @(posedge i_ref_clk);
      i_meas_start <= dup && n == 3;
      #1;
      if (n == 1) check("busy after start", o_busy, 16'h0001);
      if (o_conv.integrate === 1'b1 && rise_at == 0) begin
        rise_at = n;
        check("emitter", o_conv.emitter_on, kind == spac_pkg::KIND_PROX && regs[1][2]);
        if (kind == spac_pkg::KIND_PROX) check("range", o_conv.high_range, regs[1][5]);
        else check("range", o_conv.high_range, 16'h0000);
        check("input select", o_conv.input_sel, sel);
      end
      if (o_conv.integrate === 1'b1 && o_conv.conv_tick === 1'b1) ticks++;
      if (o_done === 1'b1) done_at = n;
    end
    if (done_at == 0) begin
      err_total++;
      give_verdict();
    end
    check("integrate start", 16'(rise_at), 16'(rc * dv + 2));
    check("done time", 16'(done_at), 16'((rc + N_CLK) * dv + 2));
    check("ticks", 16'(ticks), 16'(N_CLK));
    check("busy at done", o_busy, 16'h0000);
    repeat (2) @(posedge i_ref_clk);
    #1;
    check("idle after done", o_busy, 16'h0000);
  endtask : meas

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin : main
    logic [7:0] a;
    logic [7:0] d;
    int i;
    repeat (12) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    #1;
    check("busy idle", o_busy, 16'h0000);
    check("done idle", o_done, 16'h0000);
    check("conv idle", o_conv, 16'h0000);
    for (i = 0; i < 6; i++) begin
      regs[i] = rsts[i];
      rd(offs[i], d);
      check("reset value", d, rsts[i]);
    end
    // Random traffic over mapped registers and holes, reserved bits included
    for (int k = 0; k < 40; k++) begin
      i = {$random(seed)} % 8;
      a = (i < 6) ? offs[i] : ((i == 6) ? 8'h0D : 8'($random(seed)));
      d = 8'($random(seed));
      wr(a, d);
      i = idx(a);
      if (i >= 0) regs[i] = d & msks[i];
      rd(a, d);
      check("readback", d, (i >= 0) ? regs[i] : 8'h00);
    end
    // Mid-run reset brings the recovery register back to its default
    @(posedge i_ref_clk);
    i_rst <= 1'b1;
    repeat (2) @(posedge i_ref_clk);
    i_rst <= 1'b0;
    for (i = 0; i < 6; i++) regs[i] = rsts[i];
    rd(8'h10, d);
    check("recovery after reset", d, 16'h0070);
    meas(spac_pkg::KIND_PROX, 1'b1);
    // Every legal proximity gain, gain never above five
    for (int g = 0; g < 6; g++) begin
      set_reg(0, 8'($random(seed)) & 8'hF8 | 8'(g));
      d = 8'($random(seed));
      d[5] = g[1];
      d[2] = g[0];
      set_reg(1, d);
      meas(spac_pkg::KIND_PROX, g == 2);
    end
    // Every recovery code, one with recovery set to the gain complement
    for (int c = 0; c < 8; c++) begin
      set_reg(5, (c == 4) ? 8'h03 : 8'(c % 4));
      set_reg(4, {1'b0, 3'(c), 4'(8'($random(seed)))});
      meas(spac_pkg::KIND_VIS, c == 1);
    end
    set_reg(2, 8'h00);
    meas(spac_pkg::KIND_IR, 1'b0);
    set_reg(2, 8'h03);
    meas(spac_pkg::KIND_IR, 1'b0);
    set_reg(3, 8'h65);
    meas(spac_pkg::KIND_AUX, 1'b0);
    set_reg(3, 8'h75);
    meas(spac_pkg::KIND_AUX, 1'b1);
    give_verdict();
  end : main
endmodule : sensor_adc_measurement_config_test
